// ==== verilog/host_timer_regs.sv ====
`timescale 1ns/1ps
module host_timer_regs
    import host_timer_pkg::*;
#(
    parameter int unsigned TIMER_TICK_DIV = 100
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        host_cs_b,
    input  wire logic        host_rd_b,
    input  wire logic        host_wr_b,
    input  wire logic [7:1]  host_addr,
    input  wire logic [15:0] host_wdata,
    output logic      [15:0] host_rdata,
    output logic             host_rdata_oe,
    input  wire logic        frame_dropped,
    output logic             timer_event,
    output logic             drop_half_event,
    output logic             half_swap_active,
    input  wire logic [31:0] tx_fifo_word,
    input  wire logic        tx_word_valid,
    output logic             tx_word_ready,
    output logic      [15:0] tx_half,
    output logic             tx_half_valid,
    input  wire logic [15:0] rx_half,
    input  wire logic        rx_half_valid,
    output logic      [31:0] rx_fifo_word,
    output logic             rx_word_valid
);
    if (TIMER_TICK_DIV < 1) begin : g_bad_tick
        $error("host_timer_regs: TIMER_TICK_DIV must be at least 1");
    end

    // ****************************************************************
    // host pin synchronisers
    // ****************************************************************
    localparam int unsigned SYW = 3 + 7 + 16;

    logic [SYW-1:0] pin_meta_ff, pin_sync_ff;
    logic           s_cs_b, s_rd_b, s_wr_b, upper;
    logic [7:1]     s_addr;
    logic [15:0]    s_wdata;
    logic           rd_act_ff, wr_act_ff, rd_act, wr_act, rd_edge, wr_edge;
    logic [7:0]     ofs;
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pin_meta_ff <= {3'b111, 7'h00, 16'h0000};
            pin_sync_ff <= {3'b111, 7'h00, 16'h0000};
        end else begin
            pin_meta_ff <= {host_cs_b, host_rd_b, host_wr_b, host_addr, host_wdata};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign {s_cs_b, s_rd_b, s_wr_b, s_addr, s_wdata} = pin_sync_ff;
    assign rd_act = !s_cs_b && !s_rd_b;
    assign wr_act = !s_cs_b && !s_wr_b;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rd_act_ff <= 1'b0;
            wr_act_ff <= 1'b0;
        end else begin
            rd_act_ff <= rd_act;
            wr_act_ff <= wr_act;
        end
    end

    assign rd_edge = rd_act && !rd_act_ff;
    assign wr_edge = wr_act && !wr_act_ff;
    assign ofs     = word_offset(s_addr);
    assign upper   = pick_upper(s_addr[1], half_swap_active);

    // ****************************************************************
    // half-word swap control
    // ****************************************************************
    logic [31:0] swap_ff;
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            swap_ff <= SWAP_RST;
        end else if (wr_edge && ofs == OFS_SWAP_CTRL) begin
            if (upper) begin
                swap_ff[31:16] <= s_wdata;
            end else begin
                swap_ff[15:0] <= s_wdata;
            end
        end
    end
    assign half_swap_active = (swap_ff == SWAP_CODE);

    // ****************************************************************
    // general-purpose timer
    // ****************************************************************
    logic        timer_tick, timer_en_ff, nxt_timer_en, cfg_hi_wr, cfg_lo_wr;
    logic [15:0] preload_ff, count_ff;
    tick_divider #(.DIV (TIMER_TICK_DIV)) u_timer_tick (
        .ref_clk (ref_clk), .rst_b (rst_b), .tick (timer_tick)
    );
    assign cfg_hi_wr    = wr_edge && ofs == OFS_TIMER_CFG && upper;
    assign cfg_lo_wr    = wr_edge && ofs == OFS_TIMER_CFG && !upper;
    assign nxt_timer_en = cfg_hi_wr ? s_wdata[TIMER_EN_BIT - HALF_WIDTH] : timer_en_ff;
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            timer_en_ff <= 1'b0;
        end else begin
            timer_en_ff <= nxt_timer_en;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            preload_ff <= PRELOAD_RST;
        end else if (timer_en_ff && !nxt_timer_en) begin
            preload_ff <= PRELOAD_RST;
        end else if (cfg_lo_wr) begin
            preload_ff <= s_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            count_ff <= COUNT_RST;
        end else if (nxt_timer_en && !timer_en_ff) begin
            count_ff <= preload_ff;
        end else if (timer_en_ff && timer_tick) begin
            if (count_ff == 16'h0000) begin
                count_ff <= preload_ff;
            end else begin
                count_ff <= count_ff - 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            timer_event <= 1'b0;
        end else begin
            timer_event <= timer_en_ff && timer_tick && count_ff == 16'h0000;
        end
    end

    // ****************************************************************
    // free-running counter and snapshot
    // ****************************************************************
    logic        free_tick, free_pend_ff, free_first_up_ff, free_rd, free_capture;
    logic [31:0] free_ff, free_snap_ff;
    tick_divider #(.DIV (FREE_TICK_DIV)) u_free_tick (
        .ref_clk (ref_clk), .rst_b (rst_b), .tick (free_tick)
    );
    // no power-state input: counting never pauses
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            free_ff <= FREE_RST;
        end else if (free_tick) begin
            free_ff <= free_ff + 32'h0000_0001;
        end
    end
    assign free_rd      = rd_edge && ofs == OFS_FREE_TICK;
    assign free_capture = free_rd && (!free_pend_ff || upper == free_first_up_ff);
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            free_snap_ff     <= FREE_RST;
            free_pend_ff     <= 1'b0;
            free_first_up_ff <= 1'b0;
        end else if (free_capture) begin
            free_snap_ff     <= free_ff;
            free_pend_ff     <= 1'b1;
            free_first_up_ff <= upper;
        end else if (free_rd) begin
            free_pend_ff     <= 1'b0;
        end
    end

    // ****************************************************************
    // dropped-frame counter
    // ****************************************************************
    logic [31:0] drop_ff, drop_snap_ff;
    logic        drop_pend_ff, drop_first_up_ff, drop_rd, drop_clear;
    assign drop_rd    = rd_edge && ofs == OFS_LOST_FRAME;
    assign drop_clear = drop_rd && (!drop_pend_ff || upper == drop_first_up_ff);

    // a frame lost in the clearing cycle is kept as a count of one
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            drop_ff <= DROP_RST;
        end else if (drop_clear) begin
            drop_ff <= frame_dropped ? 32'h0000_0001 : DROP_RST;
        end else if (frame_dropped) begin
            drop_ff <= drop_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            drop_snap_ff     <= DROP_RST;
            drop_pend_ff     <= 1'b0;
            drop_first_up_ff <= 1'b0;
        end else if (drop_clear) begin
            drop_snap_ff     <= drop_ff;
            drop_pend_ff     <= 1'b1;
            drop_first_up_ff <= upper;
        end else if (drop_rd) begin
            drop_pend_ff     <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            drop_half_event <= 1'b0;
        end else begin
            drop_half_event <= frame_dropped && !drop_clear
                               && drop_ff == DROP_BELOW_MID;
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (ofs)
            OFS_TIMER_CFG:  rd_word = {2'b00, timer_en_ff, 13'h0000, preload_ff};
            OFS_TIMER_CNT:  rd_word = {16'h0000, count_ff};
            OFS_SWAP_CTRL:  rd_word = swap_ff;
            OFS_FREE_TICK:  rd_word = free_capture ? free_ff : free_snap_ff;
            OFS_LOST_FRAME: rd_word = drop_clear ? drop_ff : drop_snap_ff;
            default:        rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            host_rdata <= 16'h0000;
        end else if (rd_edge) begin
            host_rdata <= upper ? rd_word[31:16] : rd_word[15:0];
        end
    end
    assign host_rdata_oe = rd_act && rd_act_ff;

    // ****************************************************************
    // fifo half-word ordering
    // ****************************************************************
    logic        tx_busy_ff, rx_have_lo_ff;
    logic [15:0] tx_hi_ff, rx_lo_ff;
    assign tx_word_ready = !tx_busy_ff;
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tx_busy_ff    <= 1'b0;
            tx_hi_ff      <= 16'h0000;
            tx_half       <= 16'h0000;
            tx_half_valid <= 1'b0;
        end else if (tx_word_valid && !tx_busy_ff) begin
            tx_half       <= tx_fifo_word[15:0];
            tx_hi_ff      <= tx_fifo_word[31:16];
            tx_half_valid <= 1'b1;
            tx_busy_ff    <= 1'b1;
        end else if (tx_busy_ff) begin
            tx_half       <= tx_hi_ff;
            tx_half_valid <= 1'b1;
            tx_busy_ff    <= 1'b0;
        end else begin
            tx_half_valid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rx_have_lo_ff <= 1'b0;
            rx_lo_ff      <= 16'h0000;
            rx_fifo_word  <= 32'h0000_0000;
            rx_word_valid <= 1'b0;
        end else begin
            rx_word_valid <= 1'b0;
            if (rx_half_valid && !rx_have_lo_ff) begin
                rx_lo_ff      <= rx_half;
                rx_have_lo_ff <= 1'b1;
            end else if (rx_half_valid) begin
                rx_fifo_word  <= {rx_half, rx_lo_ff};
                rx_word_valid <= 1'b1;
                rx_have_lo_ff <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_timer_stop_preset: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(timer_en_ff) |-> preload_ff == PRELOAD_RST)
        else $error("preload not forced to all ones on timer halt");
    a_timer_start_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(timer_en_ff) |-> count_ff == $past(preload_ff))
        else $error("count not loaded from preload on timer start");
    a_timer_halt_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !timer_en_ff ##1 !timer_en_ff |-> $stable(count_ff))
        else $error("halted timer count moved");
    a_timer_count_down: assert property (@(posedge ref_clk) disable iff (!rst_b)
        timer_en_ff && nxt_timer_en && timer_tick && count_ff != 16'h0000
        |=> count_ff == $past(count_ff) - 16'h0001 && !timer_event)
        else $error("timer did not step down by one");
    a_timer_wrap_event: assert property (@(posedge ref_clk) disable iff (!rst_b)
        timer_en_ff && nxt_timer_en && timer_tick && count_ff == 16'h0000
        |=> timer_event && count_ff == $past(preload_ff))
        else $error("timer zero did not reload and raise its event");
    a_free_tick_step: assert property (@(posedge ref_clk) disable iff (!rst_b)
        free_tick |=> free_ff == $past(free_ff) + 32'h0000_0001 ##1 $stable(free_ff))
        else $error("free counter step wrong");
    a_free_snap_pair: assert property (@(posedge ref_clk) disable iff (!rst_b)
        free_rd && free_pend_ff && upper != free_first_up_ff
        |=> host_rdata == ($past(upper) ? $past(free_snap_ff[31:16]) : $past(free_snap_ff[15:0])))
        else $error("second free count half not from snapshot");
    a_drop_read_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
        drop_clear && !frame_dropped |=> drop_ff == DROP_RST)
        else $error("lost frame tally not cleared by read");
    a_drop_half_mark: assert property (@(posedge ref_clk) disable iff (!rst_b)
        frame_dropped && !drop_clear && drop_ff == DROP_BELOW_MID
        |=> drop_half_event && drop_ff == DROP_MID)
        else $error("half-way crossing not flagged");
    a_tx_low_first: assert property (@(posedge ref_clk) disable iff (!rst_b)
        tx_word_valid && tx_word_ready
        |=> tx_half_valid && tx_half == $past(tx_fifo_word[15:0])
        ##1 tx_half_valid && tx_half == $past(tx_fifo_word[31:16], 2))
        else $error("transmit halves out of order");
    c_timer_wrap: cover property (@(posedge ref_clk) disable iff (!rst_b)
        timer_event);
    c_drop_half: cover property (@(posedge ref_clk) disable iff (!rst_b)
        drop_half_event);
    c_free_pair: cover property (@(posedge ref_clk) disable iff (!rst_b)
        free_capture ##[1:50] free_rd && !free_capture);
    c_swapped_read: cover property (@(posedge ref_clk) disable iff (!rst_b)
        half_swap_active && rd_edge);

endmodule // host_timer_regs

// ==== inc/host_timer_pkg.sv ====
// Operation
// - Writing one to the timer enable bit starts the timer and clearing it halts the timer.
// - When the timer enable bit falls from one to zero the preload field is forced to FFFFh.
// - The 16-bit read-write preload in bits 15-0 gives the timer start value and resets to FFFFh.
// - The timer can raise host interrupt events at intervals set by its configuration register.
// - A read-only 16-bit count field always shows the present timer value and resets to FFFFh.
// - With any swap value but the swap code, A[1]=1 reaches the upper half and A[1]=0 the lower.
// - With exactly the swap code 0FFFFFFFh the half-word mapping is reversed.
// - The lower transmit half goes out first and the first received half lands in the lower half.
// - A 32-bit free-running counter starts at zero, steps once per 25MHz cycle and rolls over.
// - The first half-word read of the free-running count captures the whole count coherently.
// - The free-running counter keeps counting in every power-management state.
// - A 32-bit dropped-frame counter, reset to zero, steps by one for each discarded frame.
// - A host read of the dropped-frame counter returns its value and then clears it.
// - An event is raised when the dropped-frame counter passes from 7FFFFFFFh to 80000000h.
package host_timer_pkg;

    // ****************************************************************
    // clocking
    // ****************************************************************
    localparam int unsigned REF_CLK_HZ    = 100_000_000;
    localparam int unsigned FREE_TICK_HZ  = 25_000_000;
    localparam int unsigned FREE_TICK_DIV = REF_CLK_HZ / FREE_TICK_HZ;
    localparam int unsigned FREE_CLEAR_NS = 160;
    localparam int unsigned FREE_CLEAR_CYC =
        (FREE_CLEAR_NS * (REF_CLK_HZ / 1_000_000)) / 1000;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] OFS_TIMER_CFG  = 8'h8C;
    localparam logic [7:0] OFS_TIMER_CNT  = 8'h90;
    localparam logic [7:0] OFS_SWAP_CTRL  = 8'h98;
    localparam logic [7:0] OFS_FREE_TICK  = 8'h9C;
    localparam logic [7:0] OFS_LOST_FRAME = 8'hA0;

    // ****************************************************************
    // fields and reset values
    // ****************************************************************
    localparam int unsigned TIMER_EN_BIT   = 29;
    localparam int unsigned HALF_WIDTH     = 16;
    localparam logic [15:0] PRELOAD_RST    = 16'hFFFF;
    localparam logic [15:0] COUNT_RST      = 16'hFFFF;
    localparam logic [31:0] SWAP_RST       = 32'h0000_0000;
    localparam logic [31:0] SWAP_CODE      = 32'h0FFF_FFFF;
    localparam logic [31:0] FREE_RST       = 32'h0000_0000;
    localparam logic [31:0] DROP_RST       = 32'h0000_0000;
    localparam logic [31:0] DROP_BELOW_MID = 32'h7FFF_FFFF;
    localparam logic [31:0] DROP_MID       = 32'h8000_0000;

    // upper-half select from A[1] and the swap state
    function automatic logic pick_upper(input logic a1, input logic swapped);
        return a1 ^ swapped;
    endfunction

    // word offset of a 16-bit host address A[7:1]
    function automatic logic [7:0] word_offset(input logic [7:1] addr);
        return {addr[7:2], 2'b00};
    endfunction

endpackage

// ==== verilog/tick_divider.sv ====
`timescale 1ns/1ps
module tick_divider #(
    parameter int unsigned DIV = 4
) (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    output logic      tick
);
    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

    if (DIV < 1) begin : g_bad_div
        $error("tick_divider: DIV must be at least 1");
    end

    logic [CW-1:0] div_cnt_ff;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            div_cnt_ff <= '0;
        end else if (div_cnt_ff == CW'(DIV - 1)) begin
            div_cnt_ff <= '0;
        end else begin
            div_cnt_ff <= div_cnt_ff + 1'b1;
        end
    end

    assign tick = (div_cnt_ff == CW'(DIV - 1));

endmodule // tick_divider

// ==== testbench/host_bus_model.sv ====
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic        ref_clk,
    output logic             host_cs_b,
    output logic             host_rd_b,
    output logic             host_wr_b,
    output logic      [7:1]  host_addr,
    output logic      [15:0] host_wdata,
    input  wire logic [15:0] host_rdata,
    input  wire logic        host_rdata_oe,
    output logic             rd_done,
    output logic      [15:0] rd_val
);
    // ****************************************************************
    // one strobed access, held six edges, four idle edges after
    // ****************************************************************
    initial begin
        host_cs_b  = 1'b1;
        host_rd_b  = 1'b1;
        host_wr_b  = 1'b1;
        host_addr  = 7'h00;
        host_wdata = 16'h0000;
        rd_done    = 1'b0;
        rd_val     = 16'h0000;
    end

    task automatic access(input logic wr, input logic [7:1] a, input logic [15:0] d);
        @(posedge ref_clk);
        host_cs_b  <= 1'b0;
        host_rd_b  <= wr;
        host_wr_b  <= !wr;
        host_addr  <= a;
        host_wdata <= wr ? d : ~host_wdata;
        repeat (6) @(posedge ref_clk);
        if (!wr) begin
            rd_val  <= host_rdata_oe ? host_rdata : 16'hXXXX;
            rd_done <= 1'b1;
        end
        host_cs_b  <= 1'b1;
        host_rd_b  <= 1'b1;
        host_wr_b  <= 1'b1;
        host_addr  <= ~host_addr;
        host_wdata <= ~host_wdata;
        @(posedge ref_clk);
        rd_done <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
endmodule // host_bus_model

// ==== testbench/host_timer_regs_tb.sv ====
`timescale 1ns/1ps
module host_timer_regs_tb;
    import host_timer_pkg::*;
    localparam int DIV = 2;
    logic ref_clk, rst_b, frame_dropped, tx_word_valid, rx_half_valid;
    logic cs_b, rd_b, wr_b, oe, timer_event, drop_half_event, swap_on;
    logic tx_word_ready, tx_half_valid, rx_word_valid, rd_done;
    logic [7:1] addr;
    logic [15:0] wdata, rdata, tx_half, rx_half, rd_val;
    logic [31:0] tx_fifo_word, rx_fifo_word, seed;
    logic [31:0] rq[$], txq[$], rxq[$];
    int fail_count = 0;
    int compares = 0;
    int n, p, gap;

    host_bus_model u_host (.ref_clk(ref_clk), .host_cs_b(cs_b), .host_rd_b(rd_b),
        .host_wr_b(wr_b), .host_addr(addr), .host_wdata(wdata), .host_rdata(rdata),
        .host_rdata_oe(oe), .rd_done(rd_done), .rd_val(rd_val));
    host_timer_regs #(.TIMER_TICK_DIV(DIV)) uut (.ref_clk(ref_clk), .rst_b(rst_b),
        .host_cs_b(cs_b), .host_rd_b(rd_b), .host_wr_b(wr_b), .host_addr(addr),
        .host_wdata(wdata), .host_rdata(rdata), .host_rdata_oe(oe),
        .frame_dropped(frame_dropped), .timer_event(timer_event),
        .drop_half_event(drop_half_event), .half_swap_active(swap_on),
        .tx_fifo_word(tx_fifo_word), .tx_word_valid(tx_word_valid),
        .tx_word_ready(tx_word_ready), .tx_half(tx_half), .tx_half_valid(tx_half_valid),
        .rx_half(rx_half), .rx_half_valid(rx_half_valid), .rx_fifo_word(rx_fifo_word),
        .rx_word_valid(rx_word_valid));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:1] ha(input logic [7:0] ofs, input logic hi);
        return {ofs[7:2], hi};
    endfunction
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic rd(input logic [7:1] a, input logic [15:0] e);
        rq.push_back({16'h0000, e});
        u_host.access(1'b0, a, 16'h0000);
    endtask
    task automatic wr(input logic [7:1] a, input logic [15:0] d);
        u_host.access(1'b1, a, d);
    endtask
    task automatic wait_ev(input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge ref_clk);
            cnt++;
        end while (timer_event !== 1'b1 && cnt < lim);
    endtask
    task automatic final_report;
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************************************
    // clock, watchdog, result watcher
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        fail_count++;
        final_report();
    end
    always @(posedge ref_clk) begin
        if (rd_done === 1'b1)
            chk("host read", rq.size() != 0 ? rq.pop_front() : 32'hX, {16'h0000, rd_val});
        if (tx_half_valid === 1'b1)
            chk("tx half", txq.size() != 0 ? txq.pop_front() : 32'hX, {16'h0000, tx_half});
        if (rx_word_valid === 1'b1)
            chk("rx word", rxq.size() != 0 ? rxq.pop_front() : 32'hX, rx_fifo_word);
        if (drop_half_event !== 1'b0)
            chk("drop half", 32'd0, {31'd0, drop_half_event});
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        seed = 32'hb589;
        rst_b = 1'b0;
        frame_dropped = 1'b0;
        tx_word_valid = 1'b0;
        rx_half_valid = 1'b0;
        tx_fifo_word = 32'h0000_0000;
        rx_half = 16'h0000;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (16) @(posedge ref_clk);
        rd(ha(OFS_FREE_TICK, 1'b1), 16'h0000);
        // captured four 25 MHz steps after release
        rd(ha(OFS_FREE_TICK, 1'b0), 16'h0004);
        rd(ha(OFS_TIMER_CFG, 1'b0), PRELOAD_RST);
        rd(ha(OFS_TIMER_CFG, 1'b1), 16'h0000);
        rd(ha(OFS_TIMER_CNT, 1'b0), COUNT_RST);
        rd(ha(OFS_SWAP_CTRL, 1'b0), SWAP_RST[15:0]);
        rd(ha(8'hB0, 1'b0), 16'h0000);
        // timer period from a random small preload
        seed = lfsr(seed);
        p = 2 + int'(seed[1:0]);
        wr(ha(OFS_TIMER_CFG, 1'b0), 16'(p));
        wr(ha(OFS_TIMER_CFG, 1'b1), 16'h0001 << (TIMER_EN_BIT - HALF_WIDTH));
        wait_ev(1000, gap);
        wait_ev(1000, gap);
        chk("timer gap", 32'((p + 1) * DIV), 32'(gap));
        wr(ha(OFS_TIMER_CFG, 1'b1), 16'h0000);
        rd(ha(OFS_TIMER_CFG, 1'b0), 16'hFFFF);
        wait_ev(300, gap);
        chk("timer halted", 32'd300, 32'(gap));
        // dropped frames, read clears
        seed = lfsr(seed);
        n = 1 + int'(seed[2:0]);
        @(posedge ref_clk);
        frame_dropped <= 1'b1;
        repeat (n) @(posedge ref_clk);
        frame_dropped <= 1'b0;
        rd(ha(OFS_LOST_FRAME, 1'b0), 16'(n));
        rd(ha(OFS_LOST_FRAME, 1'b1), 16'h0000);
        rd(ha(OFS_LOST_FRAME, 1'b0), 16'h0000);
        // half-word swap on and off
        wr(ha(OFS_SWAP_CTRL, 1'b0), SWAP_CODE[15:0]);
        wr(ha(OFS_SWAP_CTRL, 1'b1), SWAP_CODE[31:16]);
        chk("swap active", 32'd1, {31'd0, swap_on});
        rd(ha(OFS_TIMER_CFG, 1'b0), 16'h0000);
        rd(ha(OFS_TIMER_CFG, 1'b1), 16'hFFFF);
        wr(ha(OFS_SWAP_CTRL, 1'b0), 16'h0000);
        chk("swap active", 32'd0, {31'd0, swap_on});
        rd(ha(OFS_SWAP_CTRL, 1'b0), SWAP_CODE[15:0]);
        // transmit and receive ordering
        repeat (2) begin
            seed = lfsr(seed);
            txq.push_back({16'h0000, seed[15:0]});
            txq.push_back({16'h0000, seed[31:16]});
            @(posedge ref_clk);
            tx_fifo_word <= seed;
            tx_word_valid <= 1'b1;
            @(posedge ref_clk);
            tx_word_valid <= 1'b0;
            tx_fifo_word <= ~seed;
            seed = lfsr(seed);
            rxq.push_back(seed);
            rx_half <= seed[15:0];
            rx_half_valid <= 1'b1;
            @(posedge ref_clk);
            rx_half <= seed[31:16];
            chk("tx ready", 32'd0, {31'd0, tx_word_ready});
            @(posedge ref_clk);
            rx_half_valid <= 1'b0;
            rx_half <= ~seed[31:16];
            repeat (4) @(posedge ref_clk);
        end
        repeat (10) @(posedge ref_clk);
        chk("queues drained", 32'd0, 32'(rq.size() + txq.size() + rxq.size()));
        final_report();
    end
endmodule // host_timer_regs_tb
